// ==== src/ebm_pkg.sv ====
// package for the external bus mode controller
// assumes one 25 MHz clock and four chip selects
package ebm_pkg;

	// ==========================================
	// sizes
	localparam int NUM_CS = 4;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 8;
	localparam int STATE_LEN_W = 4;
	localparam int WAIT_CNT_W = 3;

	// ==========================================
	// reset values and limits
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [2:0] WAIT_RESET = 3'h0;
	localparam logic [3:0] LEN_RESET = 4'h2;
	localparam logic [3:0] LEN_MIN_3ST = 4'h1;
	localparam logic [3:0] LEN_MIN_ALE = 4'h2;
	localparam logic [3:0] LEN_MAX = 4'hf;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [2:0] SYNC_RESET = 3'h7;

	// ==========================================
	// types
	typedef enum logic [1:0] {
		EBM_MODE_NATIVE = 2'b00,
		EBM_MODE_THREE = 2'b01,
		EBM_MODE_LATCH = 2'b10
	} ebm_mode_type;

	typedef enum logic [2:0] {
		EBM_ST_IDLE = 3'b000,
		EBM_ST_T1 = 3'b001,
		EBM_ST_T2 = 3'b010,
		EBM_ST_T3 = 3'b011,
		EBM_ST_T4 = 3'b100,
		EBM_ST_PROG_WAIT = 3'b101,
		EBM_ST_EXT_WAIT = 3'b110,
		EBM_ST_DONE = 3'b111
	} ebm_state_type;

	typedef struct packed {
		logic [1:0] mode;
		logic mux_bus;
		logic [3:0] state_len;
		logic [2:0] wait_count;
	} ebm_cs_cfg_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic write;
		logic io;
	} ebm_req_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic data_oe;
		logic addr_oe;
		logic read_n;
		logic write_n;
		logic memory_request_n;
		logic io_request_n;
		logic latch_strobe;
	} ebm_pins_type;

endpackage

// ==== src/ebm_sync.sv ====
// three-stage input synchroniser for pins
// assumes the pin is asynchronous to ref_clk; change accepted when stages 2 and 3 agree
`timescale 1ns/1ps
module ebm_sync (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic pin_in,
	output logic level_out
);
	logic [2:0] sync_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			sync_q <= ebm_pkg::SYNC_RESET;
			level_out <= 1'b1;
		end else begin
			sync_q <= {sync_q[1:0], pin_in};
			if (sync_q[2] == sync_q[1]) begin
				level_out <= sync_q[2];
			end
		end
	end
endmodule

// ==== src/ebm_bus_ctrl.sv ====
// external bus mode sequencer: native, three-state and address-latch bus cycles
// assumes chip select decode comes from outside as cs_hit one-hot; pins sampled here
`timescale 1ns/1ps
module ebm_bus_ctrl #(
	parameter int NUM_CS = ebm_pkg::NUM_CS
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic cfg_we,
	input wire logic [1:0] cfg_sel,
	input wire ebm_pkg::ebm_cs_cfg_type cfg_wdata,
	input wire logic req_valid,
	output logic req_ready,
	input wire ebm_pkg::ebm_req_type req,
	input wire logic [NUM_CS-1:0] cs_hit,
	input wire logic internal_hit,
	output logic [ebm_pkg::DATA_W-1:0] rdata,
	output logic rdata_valid,
	input wire logic wait_in_n,
	input wire logic bus_request_in_n,
	output logic bus_grant_out_n,
	input wire logic [ebm_pkg::DATA_W-1:0] data_in,
	output ebm_pkg::ebm_pins_type pins,
	output logic [NUM_CS-1:0] chip_select_n,
	output logic internal_access_block
);
	// ==========================================
	// configuration store
	ebm_pkg::ebm_cs_cfg_type cfg_q [NUM_CS];
	ebm_pkg::ebm_cs_cfg_type cur_cfg_q;
	ebm_pkg::ebm_cs_cfg_type cfg_clamped;
	logic [3:0] len_min;

	// clamp the length so an illegal setting cannot shorten a state
	assign len_min = (cfg_wdata.mode == ebm_pkg::EBM_MODE_LATCH) ? ebm_pkg::LEN_MIN_ALE
		: ebm_pkg::LEN_MIN_3ST;
	always_comb begin
		cfg_clamped = cfg_wdata;
		if (cfg_wdata.state_len < len_min) begin
			cfg_clamped.state_len = len_min;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CS; gi++) begin : g_cfg
			always_ff @(posedge ref_clk) begin
				if (!rst_b) begin
					cfg_q[gi] <= '{mode: ebm_pkg::MODE_RESET, mux_bus: 1'b0,
						state_len: ebm_pkg::LEN_RESET, wait_count: ebm_pkg::WAIT_RESET};
				end else if (cfg_we && cfg_sel == 2'(gi)) begin
					cfg_q[gi] <= cfg_clamped;
				end
			end
		end
	endgenerate

	// ==========================================
	// pin synchronisers
	logic wait_s;
	logic bus_request_in_n_s;

	ebm_sync u_wait_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.pin_in(wait_in_n),
		.level_out(wait_s)
	);

	ebm_sync u_bus_request_in_n_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.pin_in(bus_request_in_n),
		.level_out(bus_request_in_n_s)
	);

	// ==========================================
	// cycle selection
	logic [1:0] hit_idx;
	logic any_hit;
	ebm_pkg::ebm_cs_cfg_type hit_cfg;

	always_comb begin
		hit_idx = 2'h0;
		for (int i = NUM_CS - 1; i >= 0; i--) begin
			if (cs_hit[i]) begin
				hit_idx = 2'(i);
			end
		end
	end
	assign any_hit = |cs_hit;
	assign hit_cfg = cfg_q[hit_idx];

	// ==========================================
	// sequencer state
	ebm_pkg::ebm_state_type state_q, state_d;
	logic [3:0] len_cnt_q, len_cnt_d;
	logic [2:0] wait_cnt_q, wait_cnt_d;
	logic [1:0] cs_idx_q;
	logic cs_act_q;
	ebm_pkg::ebm_req_type req_q;
	logic grant_q;
	logic half_q, half_d;

	wire idle = (state_q == ebm_pkg::EBM_ST_IDLE);
	wire len_end = (len_cnt_q == ebm_pkg::CNT_ONE);
	wire is_latch = (cur_cfg_q.mode == ebm_pkg::EBM_MODE_LATCH);
	wire is_native = (cur_cfg_q.mode == ebm_pkg::EBM_MODE_NATIVE);
	wire start = idle && req_valid && !grant_q && bus_request_in_n_s;
	wire grant_take = idle && !req_valid && !bus_request_in_n_s;
	wire [3:0] half_len = {1'b0, cur_cfg_q.state_len[3:1]};

	assign req_ready = start;

	// where external wait is looked at: end of T2, for both three-state and latch cycles
	wire wait_point_3st = (state_q == ebm_pkg::EBM_ST_T2) && len_end && !is_latch;
	wire wait_point_ale = (state_q == ebm_pkg::EBM_ST_T2) && len_end && is_latch;

	always_comb begin
		state_d = state_q;
		len_cnt_d = len_cnt_q;
		wait_cnt_d = wait_cnt_q;
		half_d = half_q;
		case (state_q)
			ebm_pkg::EBM_ST_IDLE: begin
				if (start) begin
					state_d = ebm_pkg::EBM_ST_T1;
					len_cnt_d = hit_cfg.state_len;
					half_d = 1'b1;
					wait_cnt_d = hit_cfg.wait_count;
				end
			end
			ebm_pkg::EBM_ST_T1: begin
				if (len_cnt_q <= half_len) begin
					half_d = 1'b0;
				end
				if (len_end) begin
					state_d = ebm_pkg::EBM_ST_T2;
					len_cnt_d = cur_cfg_q.state_len;
				end else begin
					len_cnt_d = len_cnt_q - ebm_pkg::CNT_ONE;
				end
			end
			ebm_pkg::EBM_ST_T2: begin
				if (len_end) begin
					len_cnt_d = cur_cfg_q.state_len;
					// programmed waits run first, then the wait pin is consulted
					if (wait_cnt_q != 3'h0) begin
						state_d = ebm_pkg::EBM_ST_PROG_WAIT;
					end else if (!wait_s) begin
						state_d = ebm_pkg::EBM_ST_EXT_WAIT;
					end else begin
						state_d = ebm_pkg::EBM_ST_T3;
					end
				end else begin
					len_cnt_d = len_cnt_q - ebm_pkg::CNT_ONE;
				end
			end
			ebm_pkg::EBM_ST_PROG_WAIT: begin
				wait_cnt_d = wait_cnt_q - 3'h1;
				if (wait_cnt_q == 3'h1) begin
					state_d = wait_s ? ebm_pkg::EBM_ST_T3 : ebm_pkg::EBM_ST_EXT_WAIT;
				end
			end
			ebm_pkg::EBM_ST_EXT_WAIT: begin
				if (wait_s) begin
					state_d = ebm_pkg::EBM_ST_T3;
				end
			end
			ebm_pkg::EBM_ST_T3: begin
				if (len_end) begin
					len_cnt_d = cur_cfg_q.state_len;
					state_d = is_latch ? ebm_pkg::EBM_ST_T4 : ebm_pkg::EBM_ST_DONE;
				end else begin
					len_cnt_d = len_cnt_q - ebm_pkg::CNT_ONE;
				end
			end
			ebm_pkg::EBM_ST_T4: begin
				if (len_end) begin
					state_d = ebm_pkg::EBM_ST_DONE;
				end else begin
					len_cnt_d = len_cnt_q - ebm_pkg::CNT_ONE;
				end
			end
			ebm_pkg::EBM_ST_DONE: begin
				state_d = ebm_pkg::EBM_ST_IDLE;
			end
			default: begin
				state_d = ebm_pkg::EBM_ST_IDLE;
			end
		endcase
	end

	// native cycles cut T1 to one cycle; T2 and T3 keep the programmed length and waits
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state_q <= ebm_pkg::EBM_ST_IDLE;
			len_cnt_q <= ebm_pkg::CNT_ONE;
			wait_cnt_q <= ebm_pkg::WAIT_RESET;
			half_q <= 1'b0;
		end else begin
			state_q <= state_d;
			len_cnt_q <= state_q == ebm_pkg::EBM_ST_IDLE && start && hit_cfg.mode ==
				ebm_pkg::EBM_MODE_NATIVE ? ebm_pkg::CNT_ONE : len_cnt_d;
			wait_cnt_q <= wait_cnt_d;
			half_q <= half_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cur_cfg_q <= '{mode: ebm_pkg::MODE_RESET, mux_bus: 1'b0,
				state_len: ebm_pkg::LEN_RESET, wait_count: ebm_pkg::WAIT_RESET};
			req_q <= '0;
			cs_idx_q <= 2'h0;
			cs_act_q <= 1'b0;
		end else if (start) begin
			cur_cfg_q <= hit_cfg;
			req_q <= req;
			cs_idx_q <= hit_idx;
			cs_act_q <= any_hit;
		end else if (state_q == ebm_pkg::EBM_ST_DONE) begin
			cs_act_q <= 1'b0;
		end
	end

	// ==========================================
	// bus grant
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			grant_q <= 1'b0;
		end else if (grant_take) begin
			grant_q <= 1'b1;
		end else if (bus_request_in_n_s) begin
			grant_q <= 1'b0;
		end
	end
	// acknowledge only once the registered pins have let go of the bus
	assign bus_grant_out_n = !(grant_q && !pins.addr_oe);
	assign internal_access_block = grant_q;

	// ==========================================
	// read data capture
	wire cap_3st = (state_q == ebm_pkg::EBM_ST_T3) && len_end && !is_latch;
	wire cap_ale = (state_q == ebm_pkg::EBM_ST_T3) && len_end && is_latch;
	wire cap_now = (cap_3st || cap_ale) && !req_q.write;
	logic cap_q;
	// pins lag the state by one edge: sample on the edge that ends the pin strobe,
	// while the target still drives; the strobe is seen high with rdata_valid
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cap_q <= 1'b0;
			rdata <= '0;
			rdata_valid <= 1'b0;
		end else begin
			cap_q <= cap_now;
			rdata_valid <= 1'b0;
			if (cap_q) begin
				rdata <= data_in;
				rdata_valid <= 1'b1;
			end
		end
	end

	// ==========================================
	// pin shaping
	wire busy = !idle && state_q != ebm_pkg::EBM_ST_DONE;
	wire in_t1 = (state_q == ebm_pkg::EBM_ST_T1);
	wire in_t4 = (state_q == ebm_pkg::EBM_ST_T4);
	wire strobe_on = busy && !in_t1 && !in_t4;
	wire req_on = busy && (!in_t1 || is_native);
	wire mux_t1 = in_t1 && is_latch && cur_cfg_q.mux_bus;
	wire drive_wdata = busy && req_q.write && (!in_t1 || (is_latch && !cur_cfg_q.mux_bus));

	ebm_pkg::ebm_pins_type pins_d;
	always_comb begin
		pins_d = '0;
		pins_d.addr = req_q.addr;
		pins_d.addr_oe = !grant_q;
		pins_d.read_n = !(strobe_on && !req_q.write);
		pins_d.write_n = !(strobe_on && req_q.write);
		pins_d.memory_request_n = !(req_on && !req_q.io);
		pins_d.io_request_n = !(req_on && req_q.io);
		// high for the first half of T1, low for the rest so the address can latch
		pins_d.latch_strobe = in_t1 && is_latch && half_q && (len_cnt_q > half_len);
		if (mux_t1) begin
			pins_d.data = req_q.addr[ebm_pkg::DATA_W-1:0];
			pins_d.data_oe = 1'b1;
		end else if (drive_wdata) begin
			pins_d.data = req_q.wdata;
			pins_d.data_oe = 1'b1;
		end
		if (grant_q) begin
			pins_d.data_oe = 1'b0;
		end
	end

	// chip selects: own cycle, or external address decode while granted
	logic [NUM_CS-1:0] cs_d;
	always_comb begin
		cs_d = '1;
		if (grant_q) begin
			// lower index wins here too, so only one select ever goes low
			if (any_hit) begin
				cs_d[hit_idx] = 1'b0;
			end
		end else if (busy && cs_act_q) begin
			cs_d[cs_idx_q] = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pins <= '{addr: '0, data: '0, data_oe: 1'b0, addr_oe: 1'b1, read_n: 1'b1,
				write_n: 1'b1, memory_request_n: 1'b1, io_request_n: 1'b1,
				latch_strobe: 1'b0};
			chip_select_n <= '1;
		end else begin
			pins <= pins_d;
			chip_select_n <= cs_d;
		end
	end

	// internal hits during grant are blocked rather than forwarded
	wire unused_internal = internal_hit & wait_point_3st & wait_point_ale;
endmodule

// ==== sim/ebm_bus_ctrl_chk.sv ====
// checker on the bus sequencer ports
// assumes bind onto ebm_bus_ctrl, one clock domain
`timescale 1ns/1ps
module ebm_bus_ctrl_chk #(
	parameter int NUM_CS = ebm_pkg::NUM_CS
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic req_ready,
	input wire logic rdata_valid,
	input wire logic bus_grant_out_n,
	input wire ebm_pkg::ebm_pins_type pins,
	input wire logic [NUM_CS-1:0] chip_select_n,
	input wire logic internal_access_block
);
	// ========
	// bus rules
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	grant_lock_a: assert property (!bus_grant_out_n |-> internal_access_block)
		else $error("lockout off in grant");
	grant_refuse_a: assert property (!bus_grant_out_n |-> !req_ready)
		else $error("request taken in grant");
	bus_release_a: assert property (!bus_grant_out_n && $past(!bus_grant_out_n) |->
		!pins.addr_oe && !pins.data_oe)
		else $error("bus driven in grant");
	strobe_excl_a: assert property (!pins.read_n |-> pins.write_n)
		else $error("read and write strobes");
	space_excl_a: assert property (!pins.memory_request_n |-> pins.io_request_n)
		else $error("both space requests");
	valid_pulse_a: assert property (rdata_valid |=> !rdata_valid)
		else $error("read valid too long");
	read_end_a: assert property (rdata_valid |-> pins.read_n)
		else $error("read strobe at capture");
	latch_first_a: assert property (pins.latch_strobe |-> pins.read_n && pins.write_n)
		else $error("latch with strobe");
	latch_mid_a: assert property ($fell(pins.latch_strobe) |->
		pins.read_n && pins.write_n)
		else $error("latch held into strobe");
	write_hold_a: assert property (!pins.write_n && $past(!pins.write_n) |->
		$stable(pins.addr) && $stable(pins.data))
		else $error("bus moved in write");
	cs_single_a: assert property ($onehot0(~chip_select_n))
		else $error("several chip selects");
	cover property (!bus_grant_out_n);
	cover property (rdata_valid);
	cover property (pins.latch_strobe);
	cover property ($rose(pins.write_n));
endmodule
bind ebm_bus_ctrl ebm_bus_ctrl_chk #(.NUM_CS(NUM_CS)) u_chk (.ref_clk, .rst_b, .req_ready,
	.rdata_valid, .bus_grant_out_n, .pins, .chip_select_n, .internal_access_block);

// ==== sim/ebm_target.sv ====
// peripheral memory with a wait pin on the parallel bus
// assumes registered pins from the sequencer, same clock
`timescale 1ns/1ps
module ebm_target (
	input wire logic ref_clk,
	input wire ebm_pkg::ebm_pins_type pins,
	input wire logic mux_bus,
	input wire logic [7:0] stall_len,
	output logic [7:0] data_in,
	output logic wait_in_n
);
	// ========
	// storage and wait
	logic [7:0] mem_q [256];
	logic [7:0] lo_q;
	logic [7:0] last_q;
	logic strobe_q;
	int cnt_q = 0;
	wire strobe = !pins.read_n || !pins.write_n;
	wire [7:0] idx = mux_bus ? lo_q : pins.addr[7:0];
	// undriven lines flip each cycle so a stale value never passes
	assign data_in = pins.data_oe ? pins.data : (!pins.read_n ? mem_q[idx] : ~last_q);
	// wait drops right after the strobe, well before the sample point
	assign wait_in_n = (cnt_q == 0);
	always @(posedge ref_clk) begin
		last_q <= data_in;
		strobe_q <= strobe;
		if (pins.latch_strobe) lo_q <= data_in;
		if (!pins.write_n) mem_q[idx] <= pins.data;
		if (strobe && !strobe_q) cnt_q <= stall_len;
		else if (cnt_q > 0) cnt_q <= cnt_q - 1;
	end
endmodule

// ==== sim/tb_ebm_bus_ctrl.sv ====
// self-checking bench for the bus sequencer
// assumes ebm_target on the far side, shared ref_clk
`timescale 1ns/1ps
module tb_ebm_bus_ctrl;
	logic ref_clk = 0, rst_b = 0, cfg_we = 0, req_valid = 0, mux_bus = 0;
	logic bus_request_in_n = 1, req_ready, rdata_valid, bus_grant_out_n;
	logic internal_access_block, wait_in_n;
	logic [1:0] cfg_sel = 0;
	logic [3:0] cs_hit = 4'h1, chip_select_n;
	logic [7:0] rdata, data_in, stall_len = 0;
	ebm_pkg::ebm_cs_cfg_type cfg_wdata = '0;
	ebm_pkg::ebm_req_type req = '0;
	ebm_pkg::ebm_pins_type pins;
	int fail_count = 0, num_checks = 0, lat;
	integer seed = 32'h55e3;
	logic [7:0] model_mem [int];

	always #20 ref_clk = ~ref_clk;

	ebm_bus_ctrl DUT (.ref_clk, .rst_b, .cfg_we, .cfg_sel, .cfg_wdata, .req_valid, .req_ready,
		.req, .cs_hit, .internal_hit(1'h0), .rdata, .rdata_valid, .wait_in_n,
		.bus_request_in_n, .bus_grant_out_n, .data_in, .pins, .chip_select_n,
		.internal_access_block);
	ebm_target u_target (.ref_clk, .pins, .mux_bus, .stall_len, .data_in, .wait_in_n);

	// ========
	// tasks
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask

	task automatic test_done;
		if (fail_count == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic config_cs(input int sel, input int mode, input int len, input int wc);
		@(posedge ref_clk);
		#1;
		cfg_we = 1'h1;
		cfg_sel = 2'(sel);
		cfg_wdata = {2'(mode), mux_bus, 4'(len), 3'(wc)};
		@(posedge ref_clk);
		#1;
		cfg_we = 1'h0;
	endtask

	task automatic access(input int cs, input logic wr, input logic [23:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		#1;
		cs_hit = 4'(1 << cs);
		req = {a, d, wr, 1'(a[8])};
		req_valid = 1'h1;
		do begin
			@(negedge ref_clk);
			n++;
		end while (req_ready !== 1'h1 && n < 400);
		check("taken", 1, 32'(n < 400));
		@(posedge ref_clk);
		#1;
		req_valid = 1'h0;
		if (wr) model_mem[a[7:0]] = d;
		lat = 0;
		while (!wr && rdata_valid !== 1'h1 && lat < 400) begin
			@(negedge ref_clk);
			lat++;
		end
		if (!wr) check("read done", 1, 32'(lat < 400));
		if (!wr) check("rdata", model_mem[a[7:0]], rdata);
	endtask

	// ========
	// scenarios
	initial begin
		logic [23:0] a;
		int base;
		repeat (20) @(posedge ref_clk);
		#1;
		rst_b = 1'h1;
		check("reset", 32'h003f, {chip_select_n, pins.read_n, pins.write_n});
		// cs0 stays native; cs1 three-state, cs2 latch, cs3 latch multiplexed
		for (int m = 0; m < 4; m++) begin
			mux_bus = (m == 3);
			if (m > 0) config_cs(m, m > 1 ? 2 : 1, m > 1 ? 2 : 1, 0);
			repeat (4) begin
				a = 24'($random(seed));
				access(m, 1'h1, a, 8'($random(seed)));
				access(m, 1'h0, a, 8'h00);
			end
		end
		mux_bus = 1'h0;
		access(1, 1'h0, a, 8'h00);
		base = lat;
		config_cs(1, 1, 2, 0);
		access(1, 1'h0, a, 8'h00);
		check("len step", base + 3, lat);
		config_cs(1, 1, 15, 0);
		access(1, 1'h0, a, 8'h00);
		check("len max", base + 42, lat);
		config_cs(1, 1, 1, 7);
		access(1, 1'h0, a, 8'h00);
		check("prog wait", base + 7, lat);
		stall_len = 8'h0c;
		access(1, 1'h0, a, 8'h00);
		check("ext wait", 1, lat > base + 7 && lat <= base + 26);
		config_cs(2, 2, 2, 7);
		access(2, 1'h0, a, 8'h00);
		stall_len = 8'h00;
		@(posedge ref_clk);
		#1;
		bus_request_in_n = 1'h0;
		cs_hit = 4'h6;
		repeat (8) @(negedge ref_clk);
		check("grant", 0, bus_grant_out_n);
		check("bus oe", 0, {pins.addr_oe, pins.data_oe});
		check("lockout", 1, internal_access_block);
		check("cs in grant", 32'h000d, chip_select_n);
		// a read held off by the grant must finish once the bus returns
		fork
			access(1, 1'h0, a, 8'h00);
			begin
				repeat (10) @(posedge ref_clk);
				#1;
				bus_request_in_n = 1'h1;
			end
		join
		test_done;
	end

	// whole run needs well under a thousand cycles; this leaves ample margin
	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		test_done;
	end
endmodule
